// ==== hw/fc_login_regs.vh ====
// Offsets, field positions, codes and returned values of the login service block
`ifndef FC_LOGIN_REGS_VH
`define FC_LOGIN_REGS_VH
`define OFS_CTRL       6'h00
`define OFS_PL_W0      6'h04
`define OFS_PL_W1      6'h08
`define OFS_PL_W2      6'h0c
`define OFS_PL_W3      6'h10
`define OFS_PL_COMMON2 6'h14
`define OFS_LOGO_W0    6'h18
`define OFS_STATUS     6'h1c
`define OFS_PORT_ID    6'h20
`define OFS_ACC_W0     6'h24
`define OFS_ACC_W1     6'h28
`define OFS_ACC_W2     6'h2c
`define OFS_ACC_W3     6'h30
`define CTRL_PLOGI     0
`define CTRL_LOGO      1
`define CTRL_FLOGI     2
`define CTRL_IMPLICIT  3
`define CTRL_RST       4'h0
`define PL_CV_BIT      31
`define PL_IPA_HI      13
`define PL_IPA_LO      12
`define PL_RXSZ_HI     15
`define PL_CONC_LO     16
`define PL_OPEN_LO     16
`define BB_RXSZ_HI     11
`define IPA_NONE       2'b00
`define IPA_SUPPORTED  2'b01
`define EP_DISCARD     2'b00
`define EP_BOTH        2'b10
`define CAT_ONE        2'b00
`define CAT_TWO        2'b01
`define CAT_MANY       2'b11
`define RXSZ_MIN       16'h0080
`define RXSZ_MAX       16'h0840
`define RJT_LOGICAL    8'h03
`define RJT_NOT_SUPP   8'h0b
`define EXP_NONE       8'h00
`define EXP_OPTIONS    8'h01
`define EXP_INIT_CTL   8'h03
`define EXP_RXSZ       8'h07
`define EXP_CONC       8'h09
`define ACC_W0         32'h80000000
`define ACC_RXSZ       16'h0800
`define ACC_CONC       16'h00ff
`define ACC_OPEN       16'h0001
`define CMD_LOGO       32'h05000000
`define CMD_FLOGI      32'h04000000
`define CMD_ACC        32'h02000000
`define FLOGI_W1       32'h20200000
`define FLOGI_W2       32'h08000800
`define FLOGI_W17      32'h80000000
`define FLOGI_WORDS    5'd29
`define FLOGI_LAST     5'd28
`define FL_ALPA        8'h00
`define FABRIC_DID     24'hfffffe
`endif

// ==== hw/fc_login_service_param_checker.v ====
// Login service checks, logout handling and fabric login sender with Avalon-MM registers
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`include "fc_login_regs.vh"

module fc_login_service_param_checker (
    // Clock and reset
    input  wire        clk_sys_in,
    input  wire        srst_in,
    // Avalon-MM slave
    input  wire [5:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    output reg  [31:0] avs_readdata_out,
    output reg         avs_waitrequest_out,
    // Loop state from loop initialisation
    input  wire        fl_port_detected_in,
    input  wire [7:0]  loop_alpa_in,
    input  wire [63:0] port_name_in,
    input  wire [63:0] node_name_in,
    // Circuit open request
    output reg         open_req_out,
    output reg  [7:0]  open_alpa_out,
    input  wire        open_ack_in,
    // Fabric login frame out
    output reg         tx_valid_out,
    output reg  [31:0] tx_word_out,
    output reg  [23:0] tx_did_out,
    output reg         tx_last_out,
    input  wire        tx_ready_in,
    // Fabric login accept in
    input  wire        rx_acc_valid_in,
    input  wire [31:0] rx_acc_cmd_in,
    input  wire [23:0] rx_acc_did_in,
    // Own address
    output reg  [23:0] own_port_id_out,
    output reg         fabric_logged_in_out
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_OPEN = 4'b0010;
    localparam [3:0] ST_SEND = 4'b0100;
    localparam [3:0] ST_WAIT = 4'b1000;

    reg  [3:0]  state_q;
    reg  [4:0]  word_idx_q;
    reg         implicit_q;
    reg  [31:0] pl_w0_q;
    reg  [31:0] pl_w1_q;
    reg  [31:0] pl_w2_q;
    reg  [31:0] pl_w3_q;
    reg  [31:0] pl_common2_q;
    reg  [31:0] logo_w0_q;
    reg         login_valid_q;
    reg         default_params_q;
    reg         done_q;
    reg         reject_q;
    reg  [7:0]  reason_q;
    reg  [7:0]  expl_q;
    reg  [31:0] last_resp_q;
    reg  [15:0] chk_d;
    reg  [31:0] rdata_d;
    wire        req;
    wire        wr_take;
    wire        go_plogi;
    wire        go_logo;
    wire        go_flogi;
    wire [15:0] rxsz;
    wire [15:0] bb_rxsz;
    wire [31:0] acc_w1;
    wire [31:0] acc_w2;
    wire [31:0] acc_w3;

    assign req      = avs_read_in | avs_write_in;
    assign wr_take  = avs_write_in & ~avs_waitrequest_out;
    assign go_plogi = wr_take && avs_address_in == `OFS_CTRL && avs_writedata_in[`CTRL_PLOGI];
    assign go_logo  = wr_take && avs_address_in == `OFS_CTRL && avs_writedata_in[`CTRL_LOGO];
    assign go_flogi = wr_take && avs_address_in == `OFS_CTRL && avs_writedata_in[`CTRL_FLOGI];
    assign rxsz     = pl_w1_q[`PL_RXSZ_HI:0];
    assign bb_rxsz  = {4'h0, pl_common2_q[`BB_RXSZ_HI:0]};

    // Returned class 3 words: CV only, associator 00, every class 1/2/6 field zero
    assign acc_w1 = {8'h00, `EP_DISCARD, 4'h0, `CAT_ONE, `ACC_RXSZ};
    assign acc_w2 = {`ACC_CONC, 16'h0000};
    assign acc_w3 = {`ACC_OPEN, 16'h0000};

    // Reason in [15:8], explanation in [7:0]; zero means accept
    function [15:0] plogi_check;
        input [31:0] w0;
        input [15:0] sz;
        input [15:0] bb;
        input [31:0] w2;
        input [31:0] w3;
        begin
            if (!w0[`PL_CV_BIT])
                plogi_check = {`RJT_LOGICAL, `EXP_OPTIONS};
            else if (w0[`PL_IPA_HI:`PL_IPA_LO] != `IPA_NONE &&
                     w0[`PL_IPA_HI:`PL_IPA_LO] != `IPA_SUPPORTED)
                plogi_check = {`RJT_LOGICAL, `EXP_INIT_CTL};
            else if (sz < `RXSZ_MIN || sz > `RXSZ_MAX || sz[1:0] != 2'b00 || sz > bb)
                plogi_check = {`RJT_LOGICAL, `EXP_RXSZ};
            else if (w2[31:`PL_CONC_LO] == 16'h0000)
                plogi_check = {`RJT_LOGICAL, `EXP_CONC};
            else if (w3[31:`PL_OPEN_LO] == 16'h0000)
                plogi_check = {`RJT_LOGICAL, `EXP_NONE};
            else
                plogi_check = 16'h0000;
        end
    endfunction

    // Fabric login payload word by index
    function [31:0] flogi_word;
        input [4:0]  idx;
        input [63:0] pn;
        input [63:0] nn;
        begin
            case (idx)
                5'd0:    flogi_word = `CMD_FLOGI;
                5'd1:    flogi_word = `FLOGI_W1;
                5'd2:    flogi_word = `FLOGI_W2;
                5'd5:    flogi_word = pn[63:32];
                5'd6:    flogi_word = pn[31:0];
                5'd7:    flogi_word = nn[63:32];
                5'd8:    flogi_word = nn[31:0];
                5'd17:   flogi_word = `FLOGI_W17;
                default: flogi_word = 32'h00000000;
            endcase
        end
    endfunction

    always @* begin
        chk_d = plogi_check(pl_w0_q, rxsz, bb_rxsz, pl_w2_q, pl_w3_q);
        case (avs_address_in)
            `OFS_CTRL:       rdata_d = {28'h0000000, implicit_q, 3'b000};
            `OFS_PL_W0:      rdata_d = pl_w0_q;
            `OFS_PL_W1:      rdata_d = pl_w1_q;
            `OFS_PL_W2:      rdata_d = pl_w2_q;
            `OFS_PL_W3:      rdata_d = pl_w3_q;
            `OFS_PL_COMMON2: rdata_d = pl_common2_q;
            `OFS_LOGO_W0:    rdata_d = logo_w0_q;
            `OFS_STATUS:     rdata_d = {last_resp_q[31:24], 2'b00, default_params_q, |state_q[3:1],
                                        fabric_logged_in_out, login_valid_q, reject_q, done_q,
                                        reason_q, expl_q};
            `OFS_PORT_ID:    rdata_d = {8'h00, own_port_id_out};
            `OFS_ACC_W0:     rdata_d = `ACC_W0;
            `OFS_ACC_W1:     rdata_d = acc_w1;
            `OFS_ACC_W2:     rdata_d = acc_w2;
            `OFS_ACC_W3:     rdata_d = acc_w3;
            default:         rdata_d = 32'h00000000;
        endcase
    end

    // Bus slave: one wait cycle, answer on the second edge
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h00000000;
        end else begin
            avs_waitrequest_out <= ~(req & avs_waitrequest_out);
            if (avs_read_in & avs_waitrequest_out)
                avs_readdata_out <= rdata_d;
        end
    end

    // Register writes, login and logout handling
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            implicit_q       <= 1'b0;
            pl_w0_q          <= 32'h00000000;
            pl_w1_q          <= 32'h00000000;
            pl_w2_q          <= 32'h00000000;
            pl_w3_q          <= 32'h00000000;
            pl_common2_q     <= 32'h00000000;
            logo_w0_q        <= 32'h00000000;
            login_valid_q    <= 1'b0;
            default_params_q <= 1'b0;
            done_q           <= 1'b0;
            reject_q         <= 1'b0;
            reason_q         <= 8'h00;
            expl_q           <= 8'h00;
            last_resp_q      <= 32'h00000000;
        end else begin
            if (wr_take) begin
                case (avs_address_in)
                    `OFS_CTRL:       implicit_q   <= avs_writedata_in[`CTRL_IMPLICIT];
                    `OFS_PL_W0:      pl_w0_q      <= avs_writedata_in;
                    `OFS_PL_W1:      pl_w1_q      <= avs_writedata_in;
                    `OFS_PL_W2:      pl_w2_q      <= avs_writedata_in;
                    `OFS_PL_W3:      pl_w3_q      <= avs_writedata_in;
                    `OFS_PL_COMMON2: pl_common2_q <= avs_writedata_in;
                    `OFS_LOGO_W0:    logo_w0_q    <= avs_writedata_in;
                    default:         done_q       <= done_q;
                endcase
            end
            if (go_plogi) begin
                done_q      <= 1'b1;
                reject_q    <= |chk_d;
                reason_q    <= chk_d[15:8];
                expl_q      <= chk_d[7:0];
                last_resp_q <= `CMD_ACC;
                if (chk_d == 16'h0000) begin
                    login_valid_q    <= 1'b1;
                    default_params_q <= 1'b0;
                end
            end else if (go_logo) begin
                done_q      <= 1'b1;
                last_resp_q <= `CMD_ACC;
                if (logo_w0_q[23:0] != 24'h000000) begin
                    reject_q <= 1'b1;
                    reason_q <= `RJT_NOT_SUPP;
                    expl_q   <= `EXP_NONE;
                end else begin
                    reject_q         <= 1'b0;
                    reason_q         <= 8'h00;
                    expl_q           <= 8'h00;
                    login_valid_q    <= 1'b0;
                    default_params_q <= implicit_q;
                end
            end
        end
    end

    // Fabric login sequencer
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            state_q              <= ST_IDLE;
            word_idx_q           <= 5'd0;
            open_req_out         <= 1'b0;
            open_alpa_out        <= 8'h00;
            tx_valid_out         <= 1'b0;
            tx_word_out          <= 32'h00000000;
            tx_did_out           <= 24'h000000;
            tx_last_out          <= 1'b0;
            own_port_id_out      <= 24'h000000;
            fabric_logged_in_out <= 1'b0;
        end else begin
            if (!fabric_logged_in_out)
                own_port_id_out <= {16'h0000, loop_alpa_in};
            case (state_q)
                ST_IDLE: begin
                    if (go_flogi && fl_port_detected_in) begin
                        state_q              <= ST_OPEN;
                        open_req_out         <= 1'b1;
                        open_alpa_out        <= `FL_ALPA;
                        fabric_logged_in_out <= 1'b0;
                    end
                end
                ST_OPEN: begin
                    if (open_ack_in) begin
                        state_q      <= ST_SEND;
                        open_req_out <= 1'b0;
                        word_idx_q   <= 5'd1;
                        tx_valid_out <= 1'b1;
                        tx_did_out   <= `FABRIC_DID;
                        tx_word_out  <= flogi_word(5'd0, port_name_in, node_name_in);
                        tx_last_out  <= 1'b0;
                    end
                end
                ST_SEND: begin
                    if (tx_ready_in) begin
                        if (tx_last_out) begin
                            state_q      <= ST_WAIT;
                            tx_valid_out <= 1'b0;
                            tx_last_out  <= 1'b0;
                        end else begin
                            word_idx_q  <= word_idx_q + 5'd1;
                            tx_word_out <= flogi_word(word_idx_q, port_name_in, node_name_in);
                            tx_last_out <= (word_idx_q == `FLOGI_LAST);
                        end
                    end
                end
                ST_WAIT: begin
                    if (rx_acc_valid_in) begin
                        state_q <= ST_IDLE;
                        if (rx_acc_cmd_in == `CMD_ACC) begin
                            own_port_id_out      <= rx_acc_did_in;
                            fabric_logged_in_out <= 1'b1;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

// ==== tb/fc_login_service_param_checker_properties.sv ====
// Port-level assertions for the login service block
`timescale 1ns/100ps
module fc_login_props (
    // Clock and reset
    input wire logic        clk_sys_in,
    input wire logic        srst_in,
    // Bus and loop state
    input wire logic        avs_waitrequest_out,
    input wire logic        fl_port_detected_in,
    // Circuit and frame
    input wire logic        open_req_out,
    input wire logic [7:0]  open_alpa_out,
    input wire logic        open_ack_in,
    input wire logic        tx_valid_out,
    input wire logic [31:0] tx_word_out,
    input wire logic [23:0] tx_did_out,
    input wire logic        tx_last_out,
    input wire logic        tx_ready_in,
    // Accept and address
    input wire logic        rx_acc_valid_in,
    input wire logic [31:0] rx_acc_cmd_in,
    input wire logic [23:0] rx_acc_did_in,
    input wire logic [23:0] own_port_id_out,
    input wire logic        fabric_logged_in_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    a_wait_one: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");
    a_open_alpa: assert property (open_req_out |-> open_alpa_out == 8'h00)
        else $error("circuit opened to wrong loop address");
    a_open_hold: assert property (open_req_out && !open_ack_in |=> open_req_out)
        else $error("open request dropped before ack");
    a_ack_to_tx: assert property (open_req_out && open_ack_in |=> tx_valid_out)
        else $error("first word not offered after ack");
    a_frame_did: assert property (tx_valid_out |-> tx_did_out == 24'hfffffe)
        else $error("frame destination not fabric address");
    a_tx_hold: assert property (tx_valid_out && !tx_ready_in |=>
        tx_valid_out && $stable(tx_word_out) && $stable(tx_last_out))
        else $error("frame word changed while stalled");
    a_first_word: assert property ($rose(tx_valid_out) |-> tx_word_out == 32'h04000000)
        else $error("frame does not start with request word");
    a_skip_fabric: assert property (!fl_port_detected_in && !open_req_out && !tx_valid_out |=>
        !open_req_out)
        else $error("fabric login without fabric port");
    a_acc_id: assert property ($rose(fabric_logged_in_out) |-> $past(rx_acc_valid_in) &&
        $past(rx_acc_cmd_in) == 32'h02000000 && own_port_id_out == $past(rx_acc_did_in))
        else $error("own address not taken from accept");
    a_id_held: assert property (fabric_logged_in_out && $past(fabric_logged_in_out) |->
        $stable(own_port_id_out))
        else $error("own address moved after fabric login");
endmodule

// ==== tb/fc_fabric_port_model.sv ====
// Fabric loop port model: opens circuit, takes the login frame, answers it
`timescale 1ns/100ps
module fc_fabric_port_model (
    input  wire logic        clk_sys_in,
    input  wire logic        srst_in,
    input  wire logic        slow,
    input  wire logic [31:0] acc_cmd,
    input  wire logic [23:0] acc_did,
    input  wire logic        open_req_out,
    input  wire logic        tx_valid_out,
    input  wire logic [31:0] tx_word_out,
    input  wire logic        tx_last_out,
    output logic             open_ack_in,
    output logic             tx_ready_in,
    output logic             rx_acc_valid_in,
    output logic [31:0]      rx_acc_cmd_in,
    output logic [23:0]      rx_acc_did_in
);
    logic [31:0] words[$];
    int          last_at = 0;
    int          accs = 0;
    logic        pend = 0;
    initial begin
        open_ack_in = 0;
        tx_ready_in = 0;
        rx_acc_valid_in = 0;
        rx_acc_cmd_in = 32'h0;
        rx_acc_did_in = 24'h0;
    end
    always @(posedge clk_sys_in) begin
        if (!srst_in && pend) begin
            rx_acc_valid_in <= 1;
            rx_acc_cmd_in <= acc_cmd;
            rx_acc_did_in <= acc_did;
            accs++;
        end else begin
            rx_acc_valid_in <= 0;
            // Accept lines idle with changing garbage
            rx_acc_cmd_in <= ~rx_acc_cmd_in;
            rx_acc_did_in <= ~rx_acc_did_in;
        end
        if (srst_in) begin
            open_ack_in <= 0;
            tx_ready_in <= 0;
            pend <= 0;
        end else begin
            open_ack_in <= open_req_out && !open_ack_in;
            tx_ready_in <= slow ? 1'($urandom % 2) : 1'b1;
            // Accept follows one cycle after the last word is taken
            pend <= tx_valid_out && tx_ready_in && tx_last_out;
            if (tx_valid_out && tx_ready_in) begin
                words.push_back(tx_word_out);
                if (tx_last_out)
                    last_at = words.size() - 1;
            end
        end
    end
endmodule

// ==== tb/fc_login_service_param_checker_tb.sv ====
// Self-checking bench for the login service block
`timescale 1ns/100ps
`include "fc_login_regs.vh"
module fc_login_service_param_checker_tb;
    logic        clk_sys_in = 0, srst_in = 1;
    logic [5:0]  avs_address_in = 6'h00;
    logic        avs_read_in = 0, avs_write_in = 0;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
    logic        avs_waitrequest_out, fl_port_detected_in = 0;
    logic [7:0]  loop_alpa_in = 8'h00, open_alpa_out;
    logic [63:0] port_name_in = 64'h0, node_name_in = 64'h0;
    logic        open_req_out, open_ack_in, tx_valid_out, tx_last_out, tx_ready_in;
    logic [31:0] tx_word_out, rx_acc_cmd_in, q;
    logic [23:0] tx_did_out, rx_acc_did_in, own_port_id_out;
    logic        rx_acc_valid_in, fabric_logged_in_out, slow = 0;
    logic [31:0] acc_cmd = 32'h0;
    logic [23:0] acc_did = 24'h0;
    logic [15:0] szs [8] = '{16'h7c, 16'h80, 16'h840, 16'h844, 16'h82, 16'h800, 16'h600, 16'h200};
    logic [31:0] accw [4] = '{32'h80000000, 32'h00000800, 32'h00ff0000, 32'h00010000};
    int          fails = 0, cmp_count = 0, i;

    fc_login_service_param_checker u_fc_login_service_param_checker (.clk_sys_in, .srst_in,
        .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out,
        .avs_waitrequest_out, .fl_port_detected_in, .loop_alpa_in, .port_name_in, .node_name_in,
        .open_req_out, .open_alpa_out, .open_ack_in, .tx_valid_out, .tx_word_out, .tx_did_out,
        .tx_last_out, .tx_ready_in, .rx_acc_valid_in, .rx_acc_cmd_in, .rx_acc_did_in,
        .own_port_id_out, .fabric_logged_in_out);
    fc_fabric_port_model u_fab (.clk_sys_in, .srst_in, .slow, .acc_cmd, .acc_did, .open_req_out,
        .tx_valid_out, .tx_word_out, .tx_last_out, .open_ack_in, .tx_ready_in, .rx_acc_valid_in,
        .rx_acc_cmd_in, .rx_acc_did_in);

    always #10 clk_sys_in = ~clk_sys_in;

    task results;
        if (fails == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= w;
        avs_read_in <= !w;
        n = 0;
        do begin @(posedge clk_sys_in); n++; end while (avs_waitrequest_out !== 1'b0 && n < 100);
        r = avs_readdata_out;
        if (n >= 100) begin fails++; results(); end
        avs_write_in <= 0;
        avs_read_in <= 0;
        @(posedge clk_sys_in);
    endtask

    function automatic [15:0] exp_rj(input [31:0] a, b, c, d, input [11:0] m);
        int n;
        n = b[15:0];
        if (!a[31]) return 16'h0301;
        if (a[13]) return 16'h0303;
        if (n < 128 || n > 2112 || n % 4 != 0 || n > m) return 16'h0307;
        if (c[31:16] == 0) return 16'h0309;
        if (d[31:16] == 0) return 16'h0300;
        return 16'h0000;
    endfunction

    function automatic [31:0] exp_word(input int j);
        case (j)
            0: return 32'h04000000;
            1: return 32'h20200000;
            2: return 32'h08000800;
            5: return port_name_in[63:32];
            6: return port_name_in[31:0];
            7: return node_name_in[63:32];
            8: return node_name_in[31:0];
            17: return 32'h80000000;
            default: return 32'h0;
        endcase
    endfunction

    task plogi(input logic [31:0] a, b, c, d, input logic [11:0] m);
        logic [15:0] e;
        bus(1, `OFS_PL_W0, a, q);
        bus(1, `OFS_PL_W1, b, q);
        bus(1, `OFS_PL_W2, c, q);
        bus(1, `OFS_PL_W3, d, q);
        bus(1, `OFS_PL_COMMON2, {20'($urandom), m}, q);
        bus(1, `OFS_CTRL, 32'h1, q);
        bus(0, `OFS_STATUS, 32'h0, q);
        e = exp_rj(a, b, c, d, m);
        chk({q[17:16], q[15:0] & {16{q[17]}}}, {e != 0, 1'b1, e});
        if (e == 0) chk(q[18], 1);
    endtask

    task flogi(input int k);
        int n;
        u_fab.words.delete();
        bus(1, `OFS_CTRL, 32'h4, q);
        n = 0;
        while (u_fab.accs == k && n < 2000) begin @(posedge clk_sys_in); n++; end
        if (n >= 2000) begin fails++; results(); end
        repeat (3) @(posedge clk_sys_in);
        chk(u_fab.words.size(), 29);
        chk(u_fab.last_at, 28);
        for (int j = 0; j < 29; j++) chk(u_fab.words[j], exp_word(j));
    endtask

    initial begin
        q = $urandom(32'hace4);
        loop_alpa_in <= 8'($urandom);
        port_name_in <= {$urandom, $urandom};
        node_name_in <= {$urandom, $urandom};
        repeat (4) @(posedge clk_sys_in);
        srst_in <= 0;
        repeat (2) @(posedge clk_sys_in);
        chk(own_port_id_out, {16'h0, loop_alpa_in});
        for (i = 0; i < 40; i++)
            plogi({$urandom % 8 != 0, 17'($urandom), 2'($urandom), 12'($urandom)},
                  {16'($urandom), szs[$urandom % 8]}, {16'($urandom % 8), 16'($urandom)},
                  {16'($urandom % 8), 16'($urandom)}, ($urandom % 4 == 0) ? 12'h400 : 12'h840);
        plogi(32'h80000000, 32'h00000800, 32'h00010000, 32'h00010000, 12'h840);
        for (i = 0; i < 4; i++) begin
            bus(0, 6'(`OFS_ACC_W0 + 4 * i), 32'h0, q);
            chk(q, accw[i]);
        end
        for (i = 0; i < 2; i++) begin
            bus(1, `OFS_LOGO_W0, 32'h05000000 | 24'($urandom % 255 + 1), q);
            bus(1, `OFS_CTRL, {28'h0, i[0], 3'b010}, q);
            bus(0, `OFS_STATUS, 32'h0, q);
            chk(q & 32'h0007ffff, 32'h00030b00 | ((i == 0) << 18));
            bus(1, `OFS_LOGO_W0, 32'h05000000, q);
            bus(1, `OFS_CTRL, {28'h0, i[0], 3'b010}, q);
            bus(0, `OFS_STATUS, 32'h0, q);
            chk(q & 32'hff270000, 32'h02010000 | (i << 21));
        end
        bus(1, `OFS_CTRL, 32'h4, q);
        repeat (20) @(posedge clk_sys_in);
        chk(u_fab.words.size(), 0);
        fl_port_detected_in <= 1;
        acc_cmd <= 32'h01000000;
        acc_did <= 24'($urandom);
        flogi(0);
        chk(fabric_logged_in_out, 0);
        chk(own_port_id_out, {16'h0, loop_alpa_in});
        acc_cmd <= 32'h02000000;
        slow <= 1;
        flogi(1);
        chk(fabric_logged_in_out, 1);
        chk(own_port_id_out, acc_did);
        bus(0, `OFS_PORT_ID, 32'h0, q);
        chk(q, acc_did);
        results();
    end
endmodule

bind fc_login_service_param_checker fc_login_props u_props (.clk_sys_in, .srst_in, .avs_waitrequest_out,
    .fl_port_detected_in, .open_req_out, .open_alpa_out, .open_ack_in, .tx_valid_out, .tx_word_out,
    .tx_did_out, .tx_last_out, .tx_ready_in, .rx_acc_valid_in, .rx_acc_cmd_in, .rx_acc_did_in,
    .own_port_id_out, .fabric_logged_in_out);
